// ==== host_side.sv ====
// host-side serial reader: makes the shift clock and the chain input, captures output
// assumes chip select and read are driven by the bench around each frame
`timescale 1ns/1ps
module host_side (
    input wire logic start_in,
    input wire logic [15:0] chain_word_in,
    input wire logic sdo_in,
    output logic shift_clk_out,
    output logic chain_out,
    output logic [31:0] frame_out,
    output logic done_out
);
    // clock idles low between frames, never free-running
    initial begin
        shift_clk_out = 1'h0;
        chain_out = 1'h0;
        frame_out = 32'h0000_0000;
        done_out = 1'h0;
    end
    always @(posedge start_in) begin
        done_out = 1'h0;
        for (int k = 0; k < 32; k++) begin
            // chain word msb first, then a toggling filler nobody should rely on
            chain_out = (k < 16) ? chain_word_in[15 - k] : ~chain_out;
            #3;
            // sample just before the rising edge that moves the output on
            frame_out = {frame_out[30:0], sdo_in};
            shift_clk_out = 1'h1;
            #3;
            shift_clk_out = 1'h0;
        end
        chain_out = ~chain_out;
        done_out = 1'h1;
    end
endmodule

// ==== sar_adc_result_interface.sv ====
// conversion control and result output of a 16-bit successive-approximation converter
// assumes all control pins are asynchronous to clk_in; shift_clk_in comes from the host;
// sample_code_in is the comparator result, held still while a conversion runs
`timescale 1ns/1ps

// Operation
// - select pin high serial, low parallel
// - serial mode: unused data lines high impedance
// - format high offset binary, low invert msb
// - byte order high swaps bus bytes
// - parallel mode: sixteen bits, one per line
// - serial: bits 9,10,11 chain, out, clock
// - msb first, change on rising clock
// - chain input reappears after sixteen clocks
// - busy high from start to conversion end
// - drivers on only with select and read low
// - shift clock effective only with select low
// - reset aborts conversion, bus high impedance
// - power down ignores start requests
// - start falling edge holds sample, converts
// - start edges accepted regardless of select
module sar_adc_result_interface #(
    parameter int CONV_CYCLES = sar_pkg::CONV_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic shift_clk_in,
    input wire logic interface_select_in,
    input wire logic code_format_select_in,
    input wire logic byte_order_select_in,
    input wire logic chip_select_n_in,
    input wire logic read_n_in,
    input wire logic adc_reset_in,
    input wire logic power_down_request_in,
    input wire logic convert_start_n_in,
    input wire logic [15:0] sample_code_in,
    input wire logic [15:0] result_bus_in,
    output logic [15:0] result_bus_out,
    output logic [15:0] result_bus_oe_out,
    output logic busy_out,
    output logic hold_out
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] pins_s;
    logic [15:0] sample_s;
    logic ser_s;
    logic ob_s;
    logic swap_s;
    logic cs_n_s;
    logic rd_n_s;
    logic rst_s;
    logic pd_s;
    logic cnv_n_s;

    // active-low pins go in inverted so a cleared stage reads as idle, not as a start
    sync_bits #(
        .WIDTH(8)
    ) u_pin_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({interface_select_in, code_format_select_in, byte_order_select_in,
                   ~chip_select_n_in, ~read_n_in, adc_reset_in, power_down_request_in,
                   ~convert_start_n_in}),
        .sync_out(pins_s)
    );

    // comparator result is only read at the end of a conversion
    sync_bits #(
        .WIDTH(sar_pkg::WORD_W)
    ) u_code_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(sample_code_in),
        .sync_out(sample_s)
    );

    assign ser_s = pins_s[7];
    assign ob_s = pins_s[6];
    assign swap_s = pins_s[5];
    assign cs_n_s = ~pins_s[4];
    assign rd_n_s = ~pins_s[3];
    assign rst_s = pins_s[2];
    assign pd_s = pins_s[1];
    assign cnv_n_s = ~pins_s[0];

    // ------------------------------------------------------------
    // start edge detection
    // ------------------------------------------------------------
    logic cnv_n_prev_reg;
    logic start_fall;

    // reset value high like an idle pin; a pin held low at power-up is still taken as an edge once it passes the synchroniser
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnv_n_prev_reg <= 1'b1;
        end else begin
            cnv_n_prev_reg <= cnv_n_s;
        end
    end

    // chip select plays no part in starting a conversion
    assign start_fall = cnv_n_prev_reg & ~cnv_n_s;

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    sar_pkg::conv_state_e state_reg;
    logic [sar_pkg::CONV_CNT_W-1:0] conv_cnt_reg;
    logic busy_reg;
    logic hold_reg;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || rst_s) begin
            state_reg <= sar_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                sar_pkg::ST_IDLE: begin
                    if (start_fall && !pd_s) begin
                        state_reg <= sar_pkg::ST_CONVERT;
                    end
                end
                sar_pkg::ST_CONVERT: begin
                    if (conv_cnt_reg == '0) begin
                        state_reg <= sar_pkg::ST_LATCH;
                    end
                end
                sar_pkg::ST_LATCH: begin
                    state_reg <= sar_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= sar_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // internal oscillator modelled as a cycle count
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || rst_s) begin
            conv_cnt_reg <= '0;
        end else if (state_reg == sar_pkg::ST_IDLE) begin
            conv_cnt_reg <= sar_pkg::CONV_CNT_W'(CONV_CYCLES - 1);
        end else if (conv_cnt_reg != '0) begin
            conv_cnt_reg <= conv_cnt_reg - 1'b1;
        end
    end

    // busy and hold rise with the start and fall after the result is latched
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || rst_s) begin
            busy_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else if (state_reg == sar_pkg::ST_IDLE && start_fall && !pd_s) begin
            busy_reg <= 1'b1;
            hold_reg <= 1'b1;
        end else if (state_reg == sar_pkg::ST_LATCH) begin
            busy_reg <= 1'b0;
            hold_reg <= 1'b0;
        end
    end

    assign busy_out = busy_reg;
    assign hold_out = hold_reg;

    // ------------------------------------------------------------
    // result register
    // ------------------------------------------------------------
    logic [15:0] result_reg;
    logic valid_reg;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || rst_s) begin
            result_reg <= sar_pkg::RESULT_RESET;
        end else if (state_reg == sar_pkg::ST_CONVERT && conv_cnt_reg == '0) begin
            result_reg <= sample_s;
        end
    end

    // bus stays released after a reset until fresh data exists
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || rst_s) begin
            valid_reg <= 1'b0;
        end else if (state_reg == sar_pkg::ST_LATCH) begin
            valid_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // output data and drivers
    // ------------------------------------------------------------
    logic [15:0] par_data_reg;
    logic [15:0] ser_word_reg;
    logic [15:0] oe_reg;
    logic drive_en;
    logic serial_bit;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            par_data_reg <= sar_pkg::RESULT_RESET;
        end else begin
            par_data_reg <= sar_pkg::order_word(sar_pkg::format_word(result_reg, ob_s),
                                                swap_s);
        end
    end

    // serial word changes only between frames, so the shift clock side sees it still
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ser_word_reg <= sar_pkg::RESULT_RESET;
        end else if (cs_n_s) begin
            ser_word_reg <= sar_pkg::format_word(result_reg, ob_s);
        end
    end

    assign drive_en = !cs_n_s && !rd_n_s && valid_reg && !rst_s;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            oe_reg <= sar_pkg::OE_NONE;
        end else if (!drive_en) begin
            oe_reg <= sar_pkg::OE_NONE;
        end else if (ser_s) begin
            oe_reg <= sar_pkg::SER_OE_MASK;
        end else begin
            oe_reg <= sar_pkg::OE_ALL;
        end
    end

    // chip select pin itself gates the shift clock side
    serial_shifter #(
        .WIDTH(sar_pkg::WORD_W)
    ) u_shifter (
        .shift_clk_in(shift_clk_in),
        .chip_select_n_in(chip_select_n_in),
        .word_in(ser_word_reg),
        .chain_in(result_bus_in[sar_pkg::CHAIN_IN_BIT]),
        .serial_out(serial_bit)
    );

    // serial bit is not re-timed: it must follow the shift clock edge
    always_comb begin
        result_bus_out = par_data_reg;
        if (ser_s) begin
            result_bus_out[sar_pkg::SER_OUT_BIT] = serial_bit;
        end
    end

    assign result_bus_oe_out = oe_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam int BUSY_LEN = CONV_CYCLES + 1;
    logic [sar_pkg::CONV_CNT_W-1:0] busy_len_reg;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !busy_reg) begin
            busy_len_reg <= '0;
        end else if (busy_len_reg != '1) begin
            busy_len_reg <= busy_len_reg + 1'b1;
        end
    end

    a_start_busy: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg == sar_pkg::ST_IDLE && start_fall && !pd_s && !rst_s)
        |=> busy_reg && hold_reg)
        else $error("start edge did not raise busy");

    a_pd_ignore: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg == sar_pkg::ST_IDLE && pd_s) |=> !busy_reg)
        else $error("start accepted while powered down");

    a_busy_width: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ($fell(busy_reg) && !$past(rst_s) && !$past(sys_rst_in))
        |-> int'(busy_len_reg) == BUSY_LEN)
        else $error("busy length differs from conversion count");

    a_result_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in || rst_s)
        (!busy_reg && !$past(busy_reg) && !$past(rst_s) && !$past(sys_rst_in))
        |-> $stable(result_reg))
        else $error("result changed while not converting");

    a_reset_hiz: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rst_s |=> result_bus_oe_out == sar_pkg::OE_NONE && !busy_reg && !hold_reg)
        else $error("bus driven or busy after reset");

    a_serial_lines: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (ser_s && $past(ser_s)) |-> (result_bus_oe_out & ~sar_pkg::SER_OE_MASK) == '0)
        else $error("unused line driven in serial mode");

    a_oe_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (cs_n_s || rd_n_s) |=> result_bus_oe_out == sar_pkg::OE_NONE)
        else $error("drivers on without select and read");

    a_par_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!cs_n_s && !rd_n_s && !ser_s && valid_reg && !rst_s)
        |=> result_bus_oe_out == sar_pkg::OE_ALL)
        else $error("parallel bus not fully driven");

    a_twos_msb: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!ob_s && !swap_s)
        |=> par_data_reg == {~$past(result_reg[15]), $past(result_reg[14:0])})
        else $error("msb not inverted in two's complement");

    // output path follows the latched result one cycle late; the frame word does so only while chip select is high
    a_busy_cause: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(busy_reg) |-> $past(start_fall) && !$past(pd_s) && !$past(rst_s))
        else $error("busy rose without an accepted start");

    a_hold_busy: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        hold_reg == busy_reg)
        else $error("hold and busy disagree");

    a_latch_sample: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_reg == sar_pkg::ST_CONVERT && conv_cnt_reg == '0 && !rst_s)
        |=> result_reg == $past(sample_s))
        else $error("result not taken at end of count");

    a_latch_first: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        ($fell(busy_reg) && !$past(rst_s) && !$past(sys_rst_in))
        |-> $past(state_reg) == sar_pkg::ST_LATCH)
        else $error("busy fell before the result was latched");

    a_word_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!$past(cs_n_s) && !$past(sys_rst_in)) |-> $stable(ser_word_reg))
        else $error("serial word changed inside a frame");

    a_swap_bytes: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (ob_s && swap_s)
        |=> par_data_reg == {$past(result_reg[7:0]), $past(result_reg[15:8])})
        else $error("bytes not exchanged");

    a_plain_order: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (ob_s && !swap_s) |=> par_data_reg == $past(result_reg))
        else $error("offset binary word not passed straight");

    a_serial_oe: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!cs_n_s && !rd_n_s && ser_s && valid_reg && !rst_s)
        |=> result_bus_oe_out == sar_pkg::SER_OE_MASK)
        else $error("serial output line not driven alone");

    a_abort_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rst_s |=> state_reg == sar_pkg::ST_IDLE && !valid_reg)
        else $error("conversion not aborted by reset");

endmodule

// ==== sar_pkg.sv ====
// shared constants, state codes and word helpers of the converter result logic
// assumes a 25 MHz core clock and a 16-bit result word
package sar_pkg;

    // ------------------------------------------------------------
    // word layout and pin roles
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int CHAIN_IN_BIT = 9;
    localparam int SER_OUT_BIT = 10;
    localparam int SHIFT_CLK_BIT = 11;
    localparam logic [15:0] SER_OE_MASK = 16'h0400;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] OE_ALL = 16'hFFFF;
    localparam logic [15:0] OE_NONE = 16'h0000;

    // ------------------------------------------------------------
    // conversion timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CONV_TIME_NS = 2500;
    // longest time: round down, at least one cycle
    localparam int CONV_CYCLES = (CONV_TIME_NS / CLK_PERIOD_NS) < 1 ? 1
                                 : (CONV_TIME_NS / CLK_PERIOD_NS);
    localparam int CONV_CNT_W = 12;
    localparam int CHAIN_DELAY = 16;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_LATCH = 2'b11
    } conv_state_e;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] format_word(input logic [15:0] code,
                                                input logic offset_bin);
        format_word = offset_bin ? code : {~code[15], code[14:0]};
    endfunction

    function automatic logic [15:0] order_word(input logic [15:0] w, input logic swap);
        order_word = swap ? {w[7:0], w[15:8]} : w;
    endfunction

endpackage

// ==== serial_shifter.sv ====
// serial result shifter running on the host shift clock
// assumes word_in is held still while chip select is low
`timescale 1ns/1ps
module serial_shifter #(
    parameter int WIDTH = 16
) (
    input wire logic shift_clk_in,
    input wire logic chip_select_n_in,
    input wire logic [WIDTH-1:0] word_in,
    input wire logic chain_in,
    output logic serial_out
);

    logic [WIDTH-1:0] shift_reg;
    logic [4:0] edge_cnt_reg;

    // chip select high clears the frame, so edges outside it do nothing
    always_ff @(posedge shift_clk_in or posedge chip_select_n_in) begin
        if (chip_select_n_in) begin
            shift_reg <= '0;
            edge_cnt_reg <= 5'h00;
        end else begin
            if (edge_cnt_reg == 5'h00) begin
                shift_reg <= {word_in[WIDTH-2:0], chain_in};
            end else begin
                shift_reg <= {shift_reg[WIDTH-2:0], chain_in};
            end
            if (edge_cnt_reg != 5'h1F) begin
                edge_cnt_reg <= edge_cnt_reg + 5'h01;
            end
        end
    end

    // msb stands from chip select fall, before the first edge
    assign serial_out = (edge_cnt_reg == 5'h00) ? word_in[WIDTH-1] : shift_reg[WIDTH-1];

    a_msb_order: assert property (@(posedge shift_clk_in) disable iff (chip_select_n_in)
        (edge_cnt_reg != 5'h00 && int'(edge_cnt_reg) < WIDTH)
        |-> shift_reg[WIDTH-1] == word_in[WIDTH-1-int'(edge_cnt_reg)])
        else $error("serial bit out of order");

    a_chain_delay: assert property (@(posedge shift_clk_in) disable iff (chip_select_n_in)
        (int'(edge_cnt_reg) >= WIDTH) |-> shift_reg[WIDTH-1] == $past(chain_in, 16))
        else $error("chain input not delayed by sixteen clocks");

endmodule

// ==== sync_bits.sv ====
// two flip-flop synchroniser for a group of independent level signals
// assumes each bit is a slow level; a multi-bit value must be quasi-static
`timescale 1ns/1ps
module sync_bits #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule

// ==== tb_top.sv ====
// self-checking bench of the converter result logic with a host-side serial reader
// assumes the design's conversion count is shortened through its parameter
`timescale 1ns/1ps
module tb_top;
    localparam int CONV = 8;
    typedef struct {
        logic [15:0] code;
        logic fmt;
        logic swap;
        logic [15:0] want;
    } row_s;
    logic clk_in, sys_rst_in, interface_select_in, code_format_select_in;
    logic byte_order_select_in, chip_select_n_in, read_n_in, adc_reset_in;
    logic power_down_request_in, convert_start_n_in, start_frame;
    logic [15:0] sample_code_in, result_bus_out, result_bus_oe_out, chain_word;
    logic busy_out, hold_out, shift_clk, chain_bit, frame_done;
    logic [31:0] frame;
    wire logic sdo;
    int bad_count = 0;
    int n_compared = 0;
    int lat, len;
    row_s rows [5] = '{'{16'h1234, 1'h1, 1'h0, 16'h1234}, '{16'h1234, 1'h0, 1'h0, 16'h9234},
        '{16'h8001, 1'h0, 1'h1, 16'h0100}, '{16'hA5C3, 1'h1, 1'h1, 16'hC3A5},
        '{16'hFFFF, 1'h0, 1'h0, 16'h7FFF}};

    assign sdo = result_bus_oe_out[10] ? result_bus_out[10] : 1'hz;

    sar_adc_result_interface #(.CONV_CYCLES(CONV)) i_sar_adc_result_interface (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .shift_clk_in(shift_clk),
        .interface_select_in(interface_select_in),
        .code_format_select_in(code_format_select_in),
        .byte_order_select_in(byte_order_select_in), .chip_select_n_in(chip_select_n_in),
        .read_n_in(read_n_in), .adc_reset_in(adc_reset_in),
        .power_down_request_in(power_down_request_in),
        .convert_start_n_in(convert_start_n_in), .sample_code_in(sample_code_in),
        .result_bus_in({6'h00, chain_bit, 9'h000}), .result_bus_out(result_bus_out),
        .result_bus_oe_out(result_bus_oe_out), .busy_out(busy_out), .hold_out(hold_out));

    host_side i_host_side (.start_in(start_frame), .chain_word_in(chain_word),
        .sdo_in(sdo), .shift_clk_out(shift_clk), .chain_out(chain_bit),
        .frame_out(frame), .done_out(frame_done));

    initial begin
        clk_in = 1'h0;
        forever #20 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask

    // again: pulse the start pin once more while busy, which must be ignored
    task automatic convert(input bit again);
        @(posedge clk_in) convert_start_n_in <= 1'h0;
        lat = 0;
        len = 0;
        do begin
            @(negedge clk_in);
            lat++;
        end while (busy_out !== 1'h1 && lat < 20);
        check("busy delay", lat, 4);
        while (busy_out === 1'h1 && len < 40) begin
            len++;
            check("hold", hold_out, 1'h1);
            @(posedge clk_in) convert_start_n_in <= (again && (len == 3 || len == 4)) ? 1'h0 : 1'h1;
            @(negedge clk_in);
        end
        check("busy length", len, CONV + 1);
    endtask

    task automatic read_bus(input logic cs_n, input logic rd_n);
        @(posedge clk_in) begin
            chip_select_n_in <= cs_n;
            read_n_in <= rd_n;
        end
        repeat (4) @(negedge clk_in);
    endtask

    task automatic run_frame();
        int n;
        n = 0;
        @(posedge clk_in) start_frame <= 1'h1;
        @(negedge clk_in);
        while (frame_done !== 1'h1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        @(posedge clk_in) start_frame <= 1'h0;
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #100_000;
        bad_count++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {sys_rst_in, code_format_select_in, chip_select_n_in, read_n_in} = 4'hF;
        {interface_select_in, byte_order_select_in, adc_reset_in} = 3'h0;
        {power_down_request_in, start_frame} = 2'h0;
        convert_start_n_in = 1'h1;
        sample_code_in = 16'h0000;
        chain_word = 16'h5A3C;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        @(negedge clk_in);
        check("oe after reset", result_bus_oe_out, 16'h0000);
        $display("reset test done");
        foreach (rows[i]) begin
            @(posedge clk_in) begin
                sample_code_in <= rows[i].code;
                code_format_select_in <= rows[i].fmt;
                byte_order_select_in <= rows[i].swap;
            end
            convert(0);
            @(posedge clk_in) sample_code_in <= ~rows[i].code;
            read_bus(1'h0, 1'h0);
            check("oe parallel", result_bus_oe_out, 16'hFFFF);
            check("data", result_bus_out, rows[i].want);
            read_bus(1'h1, 1'h0);
            check("oe cs high", result_bus_oe_out, 16'h0000);
            $display("row %0d done", i);
        end
        @(posedge clk_in) sample_code_in <= 16'h0F0F;
        convert(1);
        repeat (6) @(negedge clk_in);
        check("no restart", busy_out, 1'h0);
        read_bus(1'h0, 1'h1);
        check("oe rd high", result_bus_oe_out, 16'h0000);
        $display("restart test done");
        read_bus(1'h0, 1'h0);
        check("data before pd", result_bus_out, 16'h8F0F);
        @(posedge clk_in) power_down_request_in <= 1'h1;
        repeat (2) @(posedge clk_in);
        convert_start_n_in <= 1'h0;
        repeat (8) @(negedge clk_in);
        check("busy powered down", busy_out, 1'h0);
        check("data kept", result_bus_out, 16'h8F0F);
        @(posedge clk_in) begin
            convert_start_n_in <= 1'h1;
            power_down_request_in <= 1'h0;
        end
        $display("power down test done");
        repeat (3) @(posedge clk_in);
        convert_start_n_in <= 1'h0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        check("busy with cs low", busy_out, 1'h1);
        @(posedge clk_in) adc_reset_in <= 1'h1;
        repeat (2) @(posedge clk_in);
        {adc_reset_in, convert_start_n_in} <= 2'h1;
        repeat (4) @(negedge clk_in);
        check("busy aborted", busy_out, 1'h0);
        check("oe after abort", result_bus_oe_out, 16'h0000);
        $display("device reset test done");
        read_bus(1'h1, 1'h1);
        @(posedge clk_in) interface_select_in <= 1'h1;
        @(posedge clk_in) sample_code_in <= 16'hB00F;
        for (int f = 1; f >= 0; f--) begin
            @(posedge clk_in) code_format_select_in <= f[0];
            convert(0);
            run_frame();
            read_bus(1'h0, 1'h0);
            check("oe serial", result_bus_oe_out, sar_pkg::SER_OE_MASK);
            run_frame();
            check("frame", frame, {f[0] ? 16'hB00F : 16'h300F, 16'h5A3C});
            read_bus(1'h1, 1'h1);
            $display("serial frame %0d done", f);
        end
        @(posedge clk_in) convert_start_n_in <= 1'h0;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'h1;
        repeat (2) @(negedge clk_in);
        check("busy in reset", {busy_out, hold_out}, 2'h0);
        check("bus in reset", {result_bus_oe_out, result_bus_out}, 32'h0000_0000);
        $display("system reset test done");
        give_verdict();
    end
endmodule
